// [verilog/serial_cpu_port.sv]
`timescale 1ns/1ps
`include "serial_port_map.svh"
// How it works
// - port works as slave, master or boot interface, one role at a time.
// - as slave, an external cpu reads and writes the internal register bank.
// - as master, core logic runs byte transfers with software chosen framing.
// - serial boot strap makes the port fetch boot bytes from serial memory.
// - as master, the device drives the serial clock out.
// - in boot role, the device drives the serial clock out.
// - in master and boot roles, returned data is sampled on the data input.
// - as slave, read data goes back on the data output.
// - in boot role, command and address bits go out on the data output.
// - as slave, select is an input; traffic counts only while it is low.
// - as master, select is driven low for each access, high otherwise.
// - in boot role, select is low while fetching and released when done.
module serial_cpu_port
    import serial_port_pkg::*;
#(
    parameter int BOOT_BYTES = 16,
    parameter int REG_ADDR_W = 4
) (
    input wire logic CORE_CLK_IN,
    input wire logic RESET_N_IN,
    input wire logic [1:0] CORE_BOOT_CONFIG_IN,
    input wire logic MASTER_MODE_IN,
    input wire logic SERIAL_PORT_CLK_IN,
    output logic SERIAL_PORT_CLK_OUT,
    output logic SERIAL_PORT_CLK_OE_OUT,
    input wire logic SERIAL_PORT_DATA_IN,
    output logic SERIAL_PORT_DATA_OUT,
    output logic SERIAL_PORT_DATA_OE_OUT,
    input wire logic SERIAL_PORT_SELECT_N_IN,
    output logic SERIAL_PORT_SELECT_N_OUT,
    output logic SERIAL_PORT_SELECT_N_OE_OUT,
    input wire logic MST_START_IN,
    input wire logic [7:0] MST_TX_DATA_IN,
    input wire logic MST_LAST_IN,
    output logic [7:0] MST_RX_DATA_OUT,
    output logic MST_DONE_OUT,
    output logic MST_BUSY_OUT,
    output logic [7:0] BOOT_DATA_OUT,
    output logic BOOT_VALID_OUT,
    output logic BOOT_DONE_OUT,
    output logic [1:0] ROLE_OUT
);
    localparam logic [2:0] HALF_C = 3'(`SCLK_HALF_CYC - 1);
    localparam logic [15:0] HDR_C = 16'(`BOOT_HDR_BYTES);
    localparam logic [15:0] TOTAL_C = 16'(`BOOT_HDR_BYTES + BOOT_BYTES);

    // synchronisers into the core domain
    logic [1:0] strap_s1_reg, strap_s2_reg;
    logic mst_s1_reg, mst_s2_reg;
    logic di_s1_reg, di_s2_reg;
    logic csn_s1_reg, csn_s2_reg;
    logic wr_s1_reg, wr_s2_reg, wr_s3_reg;
    logic rd_s1_reg, rd_s2_reg, rd_s3_reg;
    logic sdo_s1_reg, sdo_s2_reg;

    role_t role_reg;
    logic [1:0] strap_cnt_reg;
    eng_state_t state_reg;
    logic [2:0] div_reg, bit_reg;
    logic [7:0] tx_reg, rx_reg;
    logic [15:0] byte_cnt_reg;
    logic sclk_reg, csn_reg, last_reg, busy_reg;
    logic mst_done_reg, boot_valid_reg, boot_done_reg;
    logic [7:0] mst_rx_reg, boot_data_reg;
    logic clk_oe_reg, do_reg, do_oe_reg, cs_oe_reg;

    logic mem_wr_reg, mem_rd_reg, rd_cap_reg;
    logic [REG_ADDR_W-1:0] mem_waddr_reg, mem_raddr_reg;
    logic [7:0] mem_wdata_reg, rd_word_reg;

    // link domain
    logic [4:0] slv_cnt_reg;
    logic [7:0] slv_shift_reg, slv_cmd_reg, slv_wdata_reg;
    logic slv_wr_tgl_reg, slv_rd_tgl_reg, slv_do_reg;
    logic [7:0] slv_in_byte;
    logic wr_evt, rd_evt;

    regbank_if #(.AW(REG_ADDR_W), .DW(8)) bank_bus ();

    regbank #(.AW(REG_ADDR_W), .DW(8)) u_bank (
        .clk_in(CORE_CLK_IN),
        .rst_n_in(RESET_N_IN),
        .bus(bank_bus)
    );

    always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            strap_s1_reg <= 2'h0;
            strap_s2_reg <= 2'h0;
            mst_s1_reg <= 1'b0;
            mst_s2_reg <= 1'b0;
            di_s1_reg <= 1'b0;
            di_s2_reg <= 1'b0;
            csn_s1_reg <= 1'b1;
            csn_s2_reg <= 1'b1;
            wr_s1_reg <= 1'b0;
            wr_s2_reg <= 1'b0;
            wr_s3_reg <= 1'b0;
            rd_s1_reg <= 1'b0;
            rd_s2_reg <= 1'b0;
            rd_s3_reg <= 1'b0;
            sdo_s1_reg <= 1'b0;
            sdo_s2_reg <= 1'b0;
        end else begin
            strap_s1_reg <= CORE_BOOT_CONFIG_IN;
            strap_s2_reg <= strap_s1_reg;
            mst_s1_reg <= MASTER_MODE_IN;
            mst_s2_reg <= mst_s1_reg;
            di_s1_reg <= SERIAL_PORT_DATA_IN;
            di_s2_reg <= di_s1_reg;
            csn_s1_reg <= SERIAL_PORT_SELECT_N_IN;
            csn_s2_reg <= csn_s1_reg;
            wr_s1_reg <= slv_wr_tgl_reg;
            wr_s2_reg <= wr_s1_reg;
            wr_s3_reg <= wr_s2_reg;
            rd_s1_reg <= slv_rd_tgl_reg;
            rd_s2_reg <= rd_s1_reg;
            rd_s3_reg <= rd_s2_reg;
            sdo_s1_reg <= slv_do_reg;
            sdo_s2_reg <= sdo_s1_reg;
        end
    end

    assign wr_evt = wr_s2_reg ^ wr_s3_reg;
    assign rd_evt = rd_s2_reg ^ rd_s3_reg;

    // role: strap caught once the synchronisers have settled after reset
    always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            strap_cnt_reg <= 2'h0;
            role_reg <= ROLE_SLAVE;
        end else begin
            if (strap_cnt_reg != 2'h3) begin
                strap_cnt_reg <= strap_cnt_reg + 2'h1;
            end
            if (strap_cnt_reg == 2'h2) begin
                if (strap_s2_reg == `BOOT_CFG_SERIAL) begin
                    role_reg <= ROLE_BOOT;
                end else begin
                    role_reg <= mst_s2_reg ? ROLE_MASTER : ROLE_SLAVE;
                end
            end else if (strap_cnt_reg == 2'h3 && state_reg == ST_IDLE &&
                         (role_reg != ROLE_BOOT || boot_done_reg)) begin
                // role only changes between transfers, never mid byte
                role_reg <= mst_s2_reg ? ROLE_MASTER : ROLE_SLAVE;
            end
        end
    end

    function automatic logic [7:0] hdr_byte(input logic [15:0] idx);
        case (idx)
            16'h0001: hdr_byte = 8'(`BOOT_START_ADDR >> 16);
            16'h0002: hdr_byte = 8'(`BOOT_START_ADDR >> 8);
            16'h0003: hdr_byte = 8'(`BOOT_START_ADDR);
            default: hdr_byte = 8'h00;
        endcase
    endfunction

    // shift engine for master and boot roles
    always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            state_reg <= ST_IDLE;
            div_reg <= 3'h0;
            bit_reg <= 3'h0;
            tx_reg <= 8'h00;
            rx_reg <= 8'h00;
            byte_cnt_reg <= 16'h0000;
            sclk_reg <= 1'b0;
            csn_reg <= 1'b1;
            busy_reg <= 1'b0;
            last_reg <= 1'b0;
            mst_done_reg <= 1'b0;
            boot_valid_reg <= 1'b0;
            boot_done_reg <= 1'b0;
            mst_rx_reg <= 8'h00;
            boot_data_reg <= 8'h00;
        end else begin
            mst_done_reg <= 1'b0;
            boot_valid_reg <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    div_reg <= HALF_C;
                    bit_reg <= 3'h0;
                    byte_cnt_reg <= 16'h0000;
                    if (role_reg == ROLE_BOOT && !boot_done_reg) begin
                        tx_reg <= `BOOT_READ_CMD;
                        csn_reg <= 1'b0;
                        busy_reg <= 1'b1;
                        state_reg <= ST_SHIFT;
                    end else if (role_reg == ROLE_MASTER && MST_START_IN) begin
                        tx_reg <= MST_TX_DATA_IN;
                        last_reg <= MST_LAST_IN;
                        csn_reg <= 1'b0;
                        busy_reg <= 1'b1;
                        state_reg <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (div_reg != 3'h0) begin
                        div_reg <= div_reg - 3'h1;
                    end else if (!sclk_reg) begin
                        sclk_reg <= 1'b1;
                        div_reg <= HALF_C;
                    end else begin
                        // sample late in the high phase to cover the input synchroniser
                        rx_reg <= {rx_reg[6:0], di_s2_reg};
                        sclk_reg <= 1'b0;
                        tx_reg <= {tx_reg[6:0], 1'b0};
                        div_reg <= HALF_C;
                        bit_reg <= bit_reg + 3'h1;
                        if (bit_reg == 3'h7) begin
                            state_reg <= ST_NEXT;
                        end
                    end
                end
                ST_NEXT: begin
                    div_reg <= HALF_C;
                    byte_cnt_reg <= byte_cnt_reg + 16'h0001;
                    if (role_reg == ROLE_BOOT) begin
                        if (byte_cnt_reg >= HDR_C) begin
                            boot_data_reg <= rx_reg;
                            boot_valid_reg <= 1'b1;
                        end
                        if (byte_cnt_reg + 16'h0001 == TOTAL_C) begin
                            state_reg <= ST_END;
                        end else begin
                            tx_reg <= hdr_byte(byte_cnt_reg + 16'h0001);
                            state_reg <= ST_SHIFT;
                        end
                    end else begin
                        mst_rx_reg <= rx_reg;
                        mst_done_reg <= 1'b1;
                        state_reg <= last_reg ? ST_END : ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    // select stays low between bytes of one access
                    if (MST_START_IN) begin
                        tx_reg <= MST_TX_DATA_IN;
                        last_reg <= MST_LAST_IN;
                        state_reg <= ST_SHIFT;
                    end
                end
                ST_END: begin
                    csn_reg <= 1'b1;
                    busy_reg <= 1'b0;
                    if (role_reg == ROLE_BOOT) begin
                        boot_done_reg <= 1'b1;
                    end
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                    csn_reg <= 1'b1;
                    busy_reg <= 1'b0;
                    sclk_reg <= 1'b0;
                end
            endcase
        end
    end

    // pin drivers
    always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            clk_oe_reg <= 1'b0;
            cs_oe_reg <= 1'b0;
            do_reg <= 1'b0;
            do_oe_reg <= 1'b0;
        end else begin
            clk_oe_reg <= (role_reg != ROLE_SLAVE);
            cs_oe_reg <= (role_reg != ROLE_SLAVE);
            if (role_reg == ROLE_SLAVE) begin
                do_reg <= sdo_s2_reg;
                do_oe_reg <= !csn_s2_reg;
            end else begin
                do_reg <= tx_reg[7];
                do_oe_reg <= 1'b1;
            end
        end
    end

    // slave requests reach the register bank
    always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            mem_wr_reg <= 1'b0;
            mem_rd_reg <= 1'b0;
            rd_cap_reg <= 1'b0;
            mem_waddr_reg <= '0;
            mem_raddr_reg <= '0;
            mem_wdata_reg <= 8'h00;
            rd_word_reg <= 8'h00;
        end else begin
            // link words are stable long before their toggle arrives here
            mem_wr_reg <= wr_evt && role_reg == ROLE_SLAVE;
            mem_waddr_reg <= slv_cmd_reg[REG_ADDR_W-1:0];
            mem_wdata_reg <= slv_wdata_reg;
            mem_rd_reg <= rd_evt && role_reg == ROLE_SLAVE;
            mem_raddr_reg <= slv_cmd_reg[REG_ADDR_W-1:0];
            rd_cap_reg <= mem_rd_reg;
            if (rd_cap_reg) begin
                rd_word_reg <= bank_bus.rd_data;
            end
        end
    end

    assign bank_bus.wr_en = mem_wr_reg;
    assign bank_bus.wr_addr = mem_waddr_reg;
    assign bank_bus.wr_data = mem_wdata_reg;
    assign bank_bus.rd_en = mem_rd_reg;
    assign bank_bus.rd_addr = mem_raddr_reg;

    // link domain: frame counter cleared while select is high
    assign slv_in_byte = {slv_shift_reg[6:0], SERIAL_PORT_DATA_IN};

    always_ff @(posedge SERIAL_PORT_CLK_IN or posedge SERIAL_PORT_SELECT_N_IN) begin
        if (SERIAL_PORT_SELECT_N_IN) begin
            slv_cnt_reg <= 5'h00;
            slv_shift_reg <= 8'h00;
        end else begin
            slv_shift_reg <= slv_in_byte;
            if (slv_cnt_reg != `SLV_READ_LAST + 5'h01) begin
                slv_cnt_reg <= slv_cnt_reg + 5'h01;
            end
        end
    end

    // read leaves eight dummy clocks so the core can fetch the word
    always_ff @(posedge SERIAL_PORT_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            slv_cmd_reg <= 8'h00;
            slv_wdata_reg <= 8'h00;
            slv_wr_tgl_reg <= 1'b0;
            slv_rd_tgl_reg <= 1'b0;
        end else if (!SERIAL_PORT_SELECT_N_IN) begin
            if (slv_cnt_reg == `SLV_CMD_LAST) begin
                slv_cmd_reg <= slv_in_byte;
                if (slv_in_byte[`SLV_CMD_READ_BIT]) begin
                    slv_rd_tgl_reg <= !slv_rd_tgl_reg;
                end
            end
            if (slv_cnt_reg == `SLV_DATA_LAST && !slv_cmd_reg[`SLV_CMD_READ_BIT]) begin
                slv_wdata_reg <= slv_in_byte;
                slv_wr_tgl_reg <= !slv_wr_tgl_reg;
            end
        end
    end

    always_ff @(negedge SERIAL_PORT_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            slv_do_reg <= 1'b0;
        end else if (slv_cmd_reg[`SLV_CMD_READ_BIT] && slv_cnt_reg >= `SLV_READ_FIRST &&
                     slv_cnt_reg <= `SLV_READ_LAST) begin
            slv_do_reg <= rd_word_reg[3'(`SLV_READ_LAST - slv_cnt_reg)];
        end
    end

    assign SERIAL_PORT_CLK_OUT = sclk_reg;
    assign SERIAL_PORT_CLK_OE_OUT = clk_oe_reg;
    assign SERIAL_PORT_DATA_OUT = do_reg;
    assign SERIAL_PORT_DATA_OE_OUT = do_oe_reg;
    assign SERIAL_PORT_SELECT_N_OUT = csn_reg;
    assign SERIAL_PORT_SELECT_N_OE_OUT = cs_oe_reg;
    assign MST_RX_DATA_OUT = mst_rx_reg;
    assign MST_DONE_OUT = mst_done_reg;
    assign MST_BUSY_OUT = busy_reg;
    assign BOOT_DATA_OUT = boot_data_reg;
    assign BOOT_VALID_OUT = boot_valid_reg;
    assign BOOT_DONE_OUT = boot_done_reg;
    assign ROLE_OUT = role_reg;

    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RESET_N_IN);

    AST_ROLE_LEGAL: assert property (
        $changed(role_reg) |-> $past(state_reg) == ST_IDLE &&
        role_reg inside {ROLE_SLAVE, ROLE_MASTER, ROLE_BOOT})
        else $error("role changed mid transfer or holds an illegal code");
    AST_SLAVE_WRITE: assert property (
        (wr_evt && role_reg == ROLE_SLAVE) |=> bank_bus.wr_en ##1 !bank_bus.wr_en)
        else $error("slave write did not reach the register bank once");
    AST_MASTER_BYTE: assert property (
        (state_reg == ST_IDLE && role_reg == ROLE_MASTER && MST_START_IN)
        |-> ##66 mst_done_reg)
        else $error("master byte did not finish in 66 cycles");
    AST_CLK_DRIVEN: assert property (
        (role_reg != ROLE_SLAVE) |=> SERIAL_PORT_CLK_OE_OUT)
        else $error("serial clock not driven outside slave role");
    AST_SLAVE_PINS: assert property (
        (role_reg == ROLE_SLAVE) |=> !SERIAL_PORT_CLK_OE_OUT && !SERIAL_PORT_SELECT_N_OE_OUT)
        else $error("clock or select driven in slave role");
    AST_SELECT_LOW: assert property (
        (state_reg == ST_SHIFT) |-> !SERIAL_PORT_SELECT_N_OUT)
        else $error("select high during a transfer");
    AST_BOOT_RELEASE: assert property (
        $rose(boot_done_reg) |-> SERIAL_PORT_SELECT_N_OUT && !$past(SERIAL_PORT_SELECT_N_OUT))
        else $error("select not released at end of boot");
    AST_DO_FLOAT: assert property (
        (role_reg == ROLE_SLAVE && csn_s2_reg) |=> !SERIAL_PORT_DATA_OE_OUT)
        else $error("data output driven while select is high");
    AST_DO_TRACKS: assert property (
        (state_reg == ST_SHIFT && role_reg != ROLE_SLAVE) |=> SERIAL_PORT_DATA_OUT == $past(tx_reg[7]))
        else $error("data output does not follow the shift register");
    AST_SAMPLE: assert property (
        (state_reg == ST_SHIFT && sclk_reg && div_reg == 3'h0)
        |=> rx_reg[0] == $past(di_s2_reg) && !sclk_reg)
        else $error("input bit not taken at end of high phase");
    AST_READ_FETCH: assert property (
        (rd_evt && role_reg == ROLE_SLAVE) |=> bank_bus.rd_en ##1 rd_cap_reg)
        else $error("slave read not fetched within two cycles");

    COV_BOOT_DONE: cover property ($rose(boot_done_reg));
    COV_MASTER_BYTE: cover property (mst_done_reg && last_reg);
    COV_SLAVE_WRITE: cover property (bank_bus.wr_en);
    COV_SLAVE_READ: cover property (rd_cap_reg);
endmodule

// [shared/serial_port_map.svh]
`ifndef SERIAL_PORT_MAP_SVH
`define SERIAL_PORT_MAP_SVH

// core clock and serial clock timing
`define CORE_CLK_PERIOD_NS 20
`define SCLK_HALF_NS 80
// a longest time: rounds down, never below one cycle
`define SCLK_HALF_CYC ((`SCLK_HALF_NS / `CORE_CLK_PERIOD_NS) < 1 ? 1 : \
    (`SCLK_HALF_NS / `CORE_CLK_PERIOD_NS))

// strap code that selects serial boot
`define BOOT_CFG_SERIAL 2'h1

// boot memory read sequence
`define BOOT_READ_CMD 8'h03
`define BOOT_START_ADDR 24'h00_0000
`define BOOT_HDR_BYTES 4

// slave frame layout, in serial clock edges
`define SLV_CMD_READ_BIT 7
`define SLV_CMD_LAST 5'h07
`define SLV_DATA_LAST 5'h0f
`define SLV_READ_FIRST 5'h10
`define SLV_READ_LAST 5'h17

// register bank contents after reset
`define REG_RESET_VAL 8'h00

`endif

// [shared/serial_port_pkg.sv]
package serial_port_pkg;

    typedef enum logic [1:0] {
        ROLE_SLAVE = 2'b00,
        ROLE_MASTER = 2'b01,
        ROLE_BOOT = 2'b10
    } role_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SHIFT = 3'b001,
        ST_NEXT = 3'b010,
        ST_HOLD = 3'b011,
        ST_END = 3'b100
    } eng_state_t;

endpackage

// [shared/regbank_if.sv]
`timescale 1ns/1ps
interface regbank_if #(parameter int AW = 4, parameter int DW = 8);
    logic wr_en;
    logic [AW-1:0] wr_addr;
    logic [DW-1:0] wr_data;
    logic rd_en;
    logic [AW-1:0] rd_addr;
    logic [DW-1:0] rd_data;

    modport ctrl (output wr_en, output wr_addr, output wr_data,
                  output rd_en, output rd_addr, input rd_data);
    modport bank (input wr_en, input wr_addr, input wr_data,
                  input rd_en, input rd_addr, output rd_data);
endinterface

// [verilog/regbank.sv]
`timescale 1ns/1ps
`include "serial_port_map.svh"
module regbank #(parameter int AW = 4, parameter int DW = 8) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    regbank_if.bank bus
);
    logic [DW-1:0] mem_reg [2**AW];
    logic [DW-1:0] rd_data_reg;

    genvar gi;
    generate
        for (gi = 0; gi < 2**AW; gi++) begin : g_entry
            always_ff @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    mem_reg[gi] <= DW'(`REG_RESET_VAL);
                end else if (bus.wr_en && (bus.wr_addr == AW'(gi))) begin
                    mem_reg[gi] <= bus.wr_data;
                end
            end
        end
    endgenerate

    // read data held until the next read
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_reg <= '0;
        end else if (bus.rd_en) begin
            rd_data_reg <= mem_reg[bus.rd_addr];
        end
    end

    assign bus.rd_data = rd_data_reg;
endmodule

// [test/far_end.sv]
`timescale 1ns/1ps
module far_end (
    input wire logic clk_out_in,
    input wire logic clk_oe_in,
    input wire logic data_out_in,
    input wire logic sel_n_out_in,
    input wire logic sel_oe_in,
    output logic clk_wire_out,
    output logic sel_wire_out,
    output logic data_in_out
);
    logic m_clk = 1'b0;
    logic m_sel = 1'b1;
    logic m_d = 1'b0;
    logic mem_d = 1'b0;
    logic [7:0] sh = 8'h00;
    logic [7:0] pat = 8'h96;
    int bit_n = 0;
    int byte_n = 0;
    logic [7:0] got[$];
    // select has a pull-up; clock stands low outside frames
    assign clk_wire_out = clk_oe_in ? clk_out_in : m_clk;
    assign sel_wire_out = sel_oe_in ? sel_n_out_in : m_sel;
    assign data_in_out = clk_oe_in ? mem_d : m_d;
    // memory answers byte k of an access with 8'h96 ^ k, msb first
    always @(negedge sel_wire_out) begin
        bit_n = 0;
        byte_n = 0;
        pat = 8'h96;
        mem_d = pat[7];
    end
    // released line: inverse of last value, so a stale bit never passes
    always @(posedge sel_wire_out) begin
        mem_d = ~mem_d;
    end
    always @(negedge clk_out_in) if (clk_oe_in && !sel_wire_out) begin
        bit_n = bit_n + 1;
        if (bit_n == 8) begin
            bit_n = 0;
            byte_n = byte_n + 1;
        end
        pat = 8'h96 ^ 8'(byte_n);
        mem_d = pat[7 - bit_n];
    end
    always @(posedge clk_out_in) if (clk_oe_in && !sel_wire_out) begin
        sh = {sh[6:0], data_out_in};
        if (bit_n == 7) begin
            got.push_back(sh);
        end
    end
    // external master: data set on falling edge, device output sampled rising
    task automatic frame(input bit en, input logic [7:0] cmd, input logic [7:0] dat,
                         output logic [7:0] rd);
        logic [23:0] so;
        int n;
        so = {cmd, dat, 8'h00};
        n = cmd[7] ? 24 : 16;
        rd = 8'h00;
        m_sel = !en;
        #83;
        for (int i = 0; i < n; i++) begin
            m_d = so[23 - i];
            #80 m_clk = 1'b1;
            rd = {rd[6:0], data_out_in};
            #80 m_clk = 1'b0;
        end
        #80 m_sel = 1'b1;
        m_d = ~m_d;
    endtask
endmodule

// [test/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    import serial_port_pkg::*;
    typedef struct {logic [7:0] a; logic [7:0] b; logic [7:0] e;} row_t;
    localparam int NB = 4;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic mode = 1'b1;
    logic start = 1'b0;
    logic last = 1'b0;
    logic [7:0] tx = 8'h00;
    logic [1:0] cfg = 2'h1;
    logic clk_o, clk_oe, clk_w, d_in, d_o, d_oe, sel_o, sel_oe, sel_w;
    logic done, busy, bvalid, bdone;
    logic [7:0] rx, bdata, v;
    logic [1:0] role;
    int n_errors = 0;
    int n_checks = 0;
    int n_done = 0;
    int k = 0;
    int n0;
    row_t mrow[3] = '{'{8'hA5, 8'h00, 8'h96}, '{8'h3C, 8'h01, 8'h97}, '{8'h81, 8'h01, 8'h96}};
    row_t srow[5] = '{'{8'h03, 8'h5A, 8'h00}, '{8'h0F, 8'hC1, 8'h00},
        '{8'h83, 8'h00, 8'h5A}, '{8'h8F, 8'h00, 8'hC1}, '{8'h87, 8'h00, 8'h00}};
    always #10 clk = ~clk;
    always @(negedge clk) if (done === 1'b1) n_done++;
    serial_cpu_port #(.BOOT_BYTES(NB), .REG_ADDR_W(4)) DUT (
        .CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .CORE_BOOT_CONFIG_IN(cfg),
        .MASTER_MODE_IN(mode), .SERIAL_PORT_CLK_IN(clk_w), .SERIAL_PORT_CLK_OUT(clk_o),
        .SERIAL_PORT_CLK_OE_OUT(clk_oe), .SERIAL_PORT_DATA_IN(d_in),
        .SERIAL_PORT_DATA_OUT(d_o), .SERIAL_PORT_DATA_OE_OUT(d_oe),
        .SERIAL_PORT_SELECT_N_IN(sel_w), .SERIAL_PORT_SELECT_N_OUT(sel_o),
        .SERIAL_PORT_SELECT_N_OE_OUT(sel_oe), .MST_START_IN(start), .MST_TX_DATA_IN(tx),
        .MST_LAST_IN(last), .MST_RX_DATA_OUT(rx), .MST_DONE_OUT(done), .MST_BUSY_OUT(busy),
        .BOOT_DATA_OUT(bdata), .BOOT_VALID_OUT(bvalid), .BOOT_DONE_OUT(bdone),
        .ROLE_OUT(role));
    far_end far (.clk_out_in(clk_o), .clk_oe_in(clk_oe), .data_out_in(d_o),
        .sel_n_out_in(sel_o), .sel_oe_in(sel_oe), .clk_wire_out(clk_w),
        .sel_wire_out(sel_w), .data_in_out(d_in));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic pulse(input logic [7:0] b, input logic l);
        @(negedge clk);
        start = 1'b1;
        tx = b;
        last = l;
        @(negedge clk);
        start = 1'b0;
    endtask
    task automatic wait_role(input role_t r);
        for (int i = 0; i < 200 && role !== r; i++) @(negedge clk);
    endtask
    task automatic summarize();
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge clk);
        chk({clk_oe, d_oe, sel_oe, sel_o, 2'b00, role}, 8'h10);
        rst_n = 1'b1;
        $display("test reset done");
        for (int i = 0; i < 3000 && bdone !== 1'b1; i++) begin
            @(negedge clk);
            if (bvalid === 1'b1) begin
                if (k == 0) chk({5'h00, clk_oe, sel_oe, sel_o}, 8'h06);
                chk(bdata, 8'h96 ^ 8'(k + 4));
                k++;
            end
        end
        chk(8'(k), 8'(NB));
        chk({7'h00, bdone}, 8'h01);
        for (int j = 0; j < 4; j++) chk(far.got[j], j == 0 ? 8'h03 : 8'h00);
        chk({7'h00, sel_o}, 8'h01);
        wait_role(ROLE_MASTER);
        chk({6'h00, role}, {6'h00, ROLE_MASTER});
        $display("test boot done");
        far.got.delete();
        foreach (mrow[i]) begin
            pulse(mrow[i].a, mrow[i].b[0]);
            for (int j = 0; j < 100 && done !== 1'b1; j++) @(negedge clk);
            chk(rx, mrow[i].e);
            chk(far.got[i], mrow[i].a);
            repeat (2) @(negedge clk);
            chk({7'h00, sel_o}, mrow[i].b);
        end
        // second start while a byte shifts is dropped
        n0 = n_done;
        pulse(8'h42, 1'b1);
        repeat (10) @(negedge clk);
        chk({7'h00, busy}, 8'h01);
        pulse(8'hFF, 1'b1);
        repeat (150) @(negedge clk);
        chk({7'h00, busy}, 8'h00);
        chk(8'(n_done - n0), 8'h01);
        chk(far.got[3], 8'h42);
        $display("test master done");
        @(negedge clk);
        mode = 1'b0;
        wait_role(ROLE_SLAVE);
        // pin enables follow the role one cycle later
        @(negedge clk);
        chk({6'h00, clk_oe, sel_oe}, 8'h00);
        n0 = n_done;
        pulse(8'h11, 1'b1);
        repeat (100) @(negedge clk);
        chk(8'(n_done - n0), 8'h00);
        foreach (srow[i]) begin
            far.frame(1'b1, srow[i].a, srow[i].b, v);
            #400;
            if (srow[i].a[7]) chk(v, srow[i].e);
            chk({7'h00, d_oe}, 8'h00);
        end
        far.frame(1'b0, 8'h03, 8'hFF, v);
        chk({7'h00, d_oe}, 8'h00);
        #400;
        far.frame(1'b1, 8'h83, 8'h00, v);
        chk(v, 8'h5A);
        $display("test slave done");
        summarize();
    end
    initial begin
        #500000;
        n_errors++;
        summarize();
    end
endmodule
